// [include/fcclk_pkg.sv]
// Package for the fractional channel clock block: register map, field
// positions, reset values and frame geometry.
// Assumes a 32-bit APB register bus clocked by pclk at 200 MHz.
package fcclk_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [11:0] FCCLK_OFF_CFG2 = 12'h000;
  localparam logic [11:0] FCCLK_OFF_CFG3 = 12'h004;
  localparam logic [11:0] FCCLK_OFF_RXSEL = 12'h008;
  localparam logic [11:0] FCCLK_OFF_TXSEL = 12'h00C;
  localparam logic [11:0] FCCLK_OFF_STAT = 12'h010;
  // ==========================================================
  // Field positions
  localparam int FCCLK_CFG2_EN = 0;
  localparam int FCCLK_CFG2_SEL_LO = 1;
  localparam int FCCLK_CFG3_RX_EN = 0;
  localparam int FCCLK_CFG3_RX_56K = 1;
  localparam int FCCLK_CFG3_TX_EN = 2;
  localparam int FCCLK_CFG3_TX_56K = 3;
  localparam int FCCLK_STAT_LOCK = 16;
  // ==========================================================
  // Reset values
  localparam logic [2:0] FCCLK_CFG2_RST = 3'h0;
  localparam logic [3:0] FCCLK_CFG3_RST = 4'h0;
  localparam logic [31:0] FCCLK_SEL_RST = 32'h0000_0000;
  // ==========================================================
  // Frame geometry
  localparam logic [7:0] FCCLK_T1_LAST_POS = 8'hC0;
  localparam logic [2:0] FCCLK_LSB_IDX = 3'h7;
  localparam int FCCLK_PER_W = 12;
  localparam logic [11:0] FCCLK_PER_MAX = 12'hFFF;
  localparam logic [11:0] FCCLK_LOCK_TOL = 12'h001;
  localparam logic [31:0] FCCLK_UNMAPPED = 32'h0000_0000;
endpackage : fcclk_pkg

// [src/fcclk_top.sv]
// Fractional channel clock block: gapped receive/transmit channel clocks
// and a backplane clock synthesizer locked to the recovered receive clock.
// Assumes all line-timing inputs are synchronous to pclk and an APB master.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module fcclk_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic line_t1_mode,
  input wire logic rx_bit_clock,
  input wire logic rx_frame_start,
  input wire logic tx_bit_clock,
  input wire logic tx_frame_start,
  input wire logic recovered_rx_clock,
  output logic rx_channel_clock,
  output logic tx_channel_clock,
  output logic backplane_clock_out
);
  import fcclk_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic fcclk_gate(input logic [7:0] pos, input logic t1,
                                      input logic [31:0] sel, input logic is56);
    logic [7:0] p;
    logic g;
    p = t1 ? pos - 8'h01 : pos;
    g = sel[p[7:3]];
    if (is56 && (p[2:0] == FCCLK_LSB_IDX)) g = 1'b0;
    if (t1 && (pos == 8'h00)) g = 1'b0;
    return g;
  endfunction : fcclk_gate

  function automatic logic [FCCLK_PER_W-1:0] fcclk_diff(input logic [FCCLK_PER_W-1:0] a,
                                                       input logic [FCCLK_PER_W-1:0] b);
    return (a > b) ? a - b : b - a;
  endfunction : fcclk_diff

  // ==========================================================
  // APB registers
  logic [2:0] cfg2_q, cfg2_d;
  logic [3:0] cfg3_q, cfg3_d;
  logic [31:0] rxsel_q, rxsel_d, txsel_q, txsel_d;
  logic [31:0] rdata_q, rdata_d;
  logic err_q, err_d;
  logic [FCCLK_PER_W-1:0] per_q;
  logic lock_q;
  logic mapped;

  assign pready = 1'b1;
  assign prdata = rdata_q;
  assign pslverr = err_q & psel & penable;

  always_comb begin
    cfg2_d = cfg2_q;
    cfg3_d = cfg3_q;
    rxsel_d = rxsel_q;
    txsel_d = txsel_q;
    rdata_d = rdata_q;
    err_d = err_q;
    mapped = 1'b1;
    unique case (paddr)
      FCCLK_OFF_CFG2: rdata_d = {29'h0, cfg2_q};
      FCCLK_OFF_CFG3: rdata_d = {28'h0, cfg3_q};
      FCCLK_OFF_RXSEL: rdata_d = rxsel_q;
      FCCLK_OFF_TXSEL: rdata_d = txsel_q;
      FCCLK_OFF_STAT: rdata_d = {15'h0, lock_q, 4'h0, per_q};
      default: begin
        mapped = 1'b0;
        rdata_d = FCCLK_UNMAPPED;
      end
    endcase
    if (psel && !penable) begin
      err_d = ~mapped;
      if (pwrite) rdata_d = FCCLK_UNMAPPED;
    end
    if (psel && !penable && pwrite) begin
      unique case (paddr)
        FCCLK_OFF_CFG2: cfg2_d = pwdata[2:0];
        FCCLK_OFF_CFG3: cfg3_d = pwdata[3:0];
        FCCLK_OFF_RXSEL: rxsel_d = pwdata;
        FCCLK_OFF_TXSEL: txsel_d = pwdata;
        default: cfg2_d = cfg2_q;
      endcase
    end
    if (!(psel && !penable)) begin
      cfg2_d = cfg2_q;
      cfg3_d = cfg3_q;
      rxsel_d = rxsel_q;
      txsel_d = txsel_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg2_q <= FCCLK_CFG2_RST;
      cfg3_q <= FCCLK_CFG3_RST;
      rxsel_q <= FCCLK_SEL_RST;
      txsel_q <= FCCLK_SEL_RST;
      rdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else begin
      cfg2_q <= cfg2_d;
      cfg3_q <= cfg3_d;
      rxsel_q <= rxsel_d;
      txsel_q <= txsel_d;
      rdata_q <= rdata_d;
      err_q <= err_d;
    end
  end

  // ==========================================================
  // Gapped channel clocks, index 0 receive, index 1 transmit
  logic [1:0] bclk_lvl, fstart, en, is56, bprev_q, bprev_d, gate_q, gate_d;
  logic [1:0] chout_q, chout_d;
  logic [7:0] pos_q [2];
  logic [7:0] pos_d [2];
  logic [31:0] sel [2];

  assign bclk_lvl = {tx_bit_clock, rx_bit_clock};
  assign fstart = {tx_frame_start, rx_frame_start};
  assign en = {cfg3_q[FCCLK_CFG3_TX_EN], cfg3_q[FCCLK_CFG3_RX_EN]};
  assign is56 = {cfg3_q[FCCLK_CFG3_TX_56K], cfg3_q[FCCLK_CFG3_RX_56K]};
  assign sel[0] = rxsel_q;
  assign sel[1] = txsel_q;
  assign rx_channel_clock = chout_q[0];
  assign tx_channel_clock = chout_q[1];

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      bprev_d[i] = bclk_lvl[i];
      pos_d[i] = pos_q[i];
      gate_d[i] = gate_q[i];
      if (bclk_lvl[i] && !bprev_q[i]) begin
        if (fstart[i]) pos_d[i] = 8'h00;
        else if (line_t1_mode && pos_q[i] == FCCLK_T1_LAST_POS) pos_d[i] = 8'h00;
        else pos_d[i] = pos_q[i] + 8'h01;
        gate_d[i] = fcclk_gate(pos_d[i], line_t1_mode, sel[i], is56[i]);
      end
      chout_d[i] = en[i] & bclk_lvl[i] & gate_d[i];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bprev_q <= 2'b00;
      gate_q <= 2'b00;
      chout_q <= 2'b00;
      pos_q[0] <= 8'h00;
      pos_q[1] <= 8'h00;
    end else begin
      bprev_q <= bprev_d;
      gate_q <= gate_d;
      chout_q <= chout_d;
      pos_q[0] <= pos_d[0];
      pos_q[1] <= pos_d[1];
    end
  end

  // ==========================================================
  // Backplane synthesizer: measures the recovered clock period and
  // regenerates 1, 2, 4 or 8 times its frequency, phase-realigned on every rising reference edge
  logic rref_q, rref_d, bp_q, bp_d, lock_d;
  logic [FCCLK_PER_W-1:0] per_d, mcnt_q, mcnt_d, scnt_q, scnt_d, half;
  logic rref_rise;

  assign rref_rise = recovered_rx_clock & ~rref_q;
  assign half = per_q >> ({1'b0, cfg2_q[FCCLK_CFG2_SEL_LO +: 2]} + 3'h1);
  assign backplane_clock_out = bp_q;

  always_comb begin
    rref_d = recovered_rx_clock;
    per_d = per_q;
    lock_d = lock_q;
    mcnt_d = (mcnt_q == FCCLK_PER_MAX) ? mcnt_q : mcnt_q + 12'h001;
    scnt_d = scnt_q + 12'h001;
    bp_d = bp_q;
    if (rref_rise) begin
      per_d = mcnt_q + 12'h001;
      lock_d = (fcclk_diff(per_q, per_d) <= FCCLK_LOCK_TOL) && (mcnt_q != FCCLK_PER_MAX);
      mcnt_d = 12'h000;
      scnt_d = 12'h000;
      bp_d = 1'b1;
    end else if (half != 12'h000 && scnt_q >= half - 12'h001) begin
      scnt_d = 12'h000;
      bp_d = ~bp_q;
    end
    if (!cfg2_q[FCCLK_CFG2_EN] || !lock_d) bp_d = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rref_q <= 1'b0;
      per_q <= 12'h000;
      lock_q <= 1'b0;
      mcnt_q <= 12'h000;
      scnt_q <= 12'h000;
      bp_q <= 1'b0;
    end else begin
      rref_q <= rref_d;
      per_q <= per_d;
      lock_q <= lock_d;
      mcnt_q <= mcnt_d;
      scnt_q <= scnt_d;
      bp_q <= bp_d;
    end
  end
endmodule : fcclk_top
`default_nettype wire

// [tb/fcclk_chk.sv]
// Checker for the fractional channel clock block, bound to its top.
// Assumes one pclk domain and APB writes taken at the setup edge.
`timescale 1ns/100ps
`default_nettype none
module fcclk_chk import fcclk_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic line_t1_mode,
  input wire logic rx_bit_clock,
  input wire logic rx_frame_start,
  input wire logic tx_bit_clock,
  input wire logic rx_channel_clock,
  input wire logic tx_channel_clock,
  input wire logic backplane_clock_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========
  // Shadow of the enable bits
  logic [3:0] c3_q;
  logic c2_q;
  logic wr;
  assign wr = psel && !penable && pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) {c3_q, c2_q} <= '0;
    else if (wr && paddr == FCCLK_OFF_CFG3) c3_q <= pwdata[3:0];
    else if (wr && paddr == FCCLK_OFF_CFG2) c2_q <= pwdata[0];
  end
  sequence s_fbit;
    line_t1_mode && rx_frame_start && $rose(rx_bit_clock);
  endsequence
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_idle: assert property (!(psel && penable) |-> !pslverr)
    else $error("pslverr outside access");
  a_rx_off: assert property (!c3_q[0] && !$past(c3_q[0]) |-> !rx_channel_clock)
    else $error("rx clock while disabled");
  a_tx_off: assert property (!c3_q[2] && !$past(c3_q[2]) |-> !tx_channel_clock)
    else $error("tx clock while disabled");
  a_rx_gate: assert property (rx_channel_clock |-> $past(rx_bit_clock))
    else $error("rx clock without bit clock");
  a_tx_gate: assert property (tx_channel_clock |-> $past(tx_bit_clock))
    else $error("tx clock without bit clock");
  a_bp_off: assert property (!c2_q && !$past(c2_q) |-> !backplane_clock_out)
    else $error("backplane clock while disabled");
  a_fbit_gap: assert property (s_fbit |=> !rx_channel_clock [*4])
    else $error("rx clock on framing bit");
endmodule : fcclk_chk
bind fcclk_top fcclk_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .line_t1_mode(line_t1_mode), .rx_bit_clock(rx_bit_clock), .rx_frame_start(rx_frame_start),
  .tx_bit_clock(tx_bit_clock), .rx_channel_clock(rx_channel_clock),
  .tx_channel_clock(tx_channel_clock), .backplane_clock_out(backplane_clock_out)
);
`default_nettype wire

// [tb/fcclk_far.sv]
// Far-end model: line bit and frame timing, reference clock, pulse counts.
// Assumes the block samples every input on pclk.
`timescale 1ns/100ps
`default_nettype none
module fcclk_far (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic t1,
  input wire logic rx_ck,
  input wire logic tx_ck,
  input wire logic bp_ck,
  output logic bit_ck,
  output logic fs,
  output logic ref_ck,
  output logic frm,
  output logic [8:0] rx_n,
  output logic [8:0] tx_n,
  output logic [15:0] bp_n
);
  // ==========
  // Bit period 4 pclk, reference period 16 pclk
  logic [1:0] ph_q;
  logic [2:0] rp_q;
  logic [8:0] pos_q, rc_q, tc_q;
  logic rx_q, tx_q, bp_q;
  assign bit_ck = ph_q[1];
  assign fs = (pos_q == 9'h000);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ph_q, rp_q, pos_q, rc_q, tc_q, rx_q, tx_q, bp_q} <= '0;
      {ref_ck, frm, rx_n, tx_n, bp_n} <= '0;
    end else begin
      ph_q <= ph_q + 2'h1;
      rp_q <= rp_q + 3'h1;
      ref_ck <= ref_ck ^ (rp_q == 3'h7);
      {rx_q, tx_q, bp_q} <= {rx_ck, tx_ck, bp_ck};
      bp_n <= bp_n + 16'(bp_ck && !bp_q);
      rc_q <= rc_q + 9'(rx_ck && !rx_q);
      tc_q <= tc_q + 9'(tx_ck && !tx_q);
      frm <= fs && ph_q == 2'h1;
      if (ph_q == 2'h3) pos_q <= (pos_q == (t1 ? 9'h0C0 : 9'h0FF)) ? 9'h000 : pos_q + 9'h001;
      if (fs && ph_q == 2'h1) begin
        {rx_n, tx_n, rc_q, tc_q} <= {rc_q, tc_q, 18'h0};
      end
    end
  end
endmodule : fcclk_far
`default_nettype wire

// [tb/testbench.sv]
// Testbench: register access, gapped channel clocks and backplane clock.
// Assumes the far-end model supplies line timing and counts pulses.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import fcclk_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, t1 = 1'b1;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd = 32'h0;
  logic er = 1'b0;
  logic pready, pslverr, bit_ck, fs, ref_ck, rx_ck, tx_ck, bp_ck, frm;
  logic [8:0] rx_n, tx_n;
  logic [15:0] bp_n, n;
  int error_cnt = 0, comparisons = 0;
  initial forever #2.5 pclk = ~pclk;
  fcclk_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .line_t1_mode(t1), .rx_bit_clock(bit_ck), .rx_frame_start(fs),
    .tx_bit_clock(bit_ck), .tx_frame_start(fs), .recovered_rx_clock(ref_ck),
    .rx_channel_clock(rx_ck), .tx_channel_clock(tx_ck), .backplane_clock_out(bp_ck));
  fcclk_far u_far (.pclk, .presetn, .t1, .rx_ck, .tx_ck, .bp_ck, .bit_ck, .fs, .ref_ck, .frm,
    .rx_n, .tx_n, .bp_n);
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic frame(input logic [3:0] c, input logic [31:0] rs, ts, input logic [8:0] er, et);
    apb(1'b1, FCCLK_OFF_RXSEL, rs);
    apb(1'b1, FCCLK_OFF_TXSEL, ts);
    apb(1'b1, FCCLK_OFF_CFG3, {28'h0, c});
    repeat (2) @(posedge frm);
    // Counts are loaded on the frm edge itself; read them one clock later
    @(posedge pclk);
    chk({23'h0, rx_n}, {23'h0, er});
    chk({23'h0, tx_n}, {23'h0, et});
  endtask : frame
  task automatic t_regs;
    apb(1'b0, FCCLK_OFF_CFG3, 32'h0);
    chk(rd, {28'h0, FCCLK_CFG3_RST});
    chk({31'h0, er}, 32'h0);
    apb(1'b1, FCCLK_OFF_CFG3, 32'hFFFF_FFFF);
    apb(1'b0, FCCLK_OFF_CFG3, 32'h0);
    chk(rd, 32'h0000_000F);
    apb(1'b0, 12'h014, 32'h0);
    chk(rd, FCCLK_UNMAPPED);
    chk({31'h0, er}, 32'h1);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_rx64;
    frame(4'h1, 32'h8080_0001, 32'hFFFF_FFFF, 9'h010, 9'h000);
    $display("t_rx64 done");
  endtask : t_rx64
  task automatic t_56k;
    frame(4'h7, 32'h0000_0002, 32'h0000_0002, 9'h007, 9'h008);
    $display("t_56k done");
  endtask : t_56k
  task automatic t_tx;
    frame(4'h4, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 9'h000, 9'h0C0);
    $display("t_tx done");
  endtask : t_tx
  task automatic t_e1;
    t1 <= 1'b0;
    frame(4'hD, 32'hFFFF_FFFF, 32'h0000_0001, 9'h100, 9'h007);
    $display("t_e1 done");
  endtask : t_e1
  task automatic t_bp;
    apb(1'b1, FCCLK_OFF_CFG2, 32'h0000_0001);
    for (int i = 0; i < 50 && rd[FCCLK_STAT_LOCK] !== 1'b1; i++) apb(1'b0, FCCLK_OFF_STAT, 32'h0);
    chk({31'h0, rd[FCCLK_STAT_LOCK]}, 32'h1);
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, FCCLK_OFF_CFG2, {29'h0, s[1:0], 1'b1});
      repeat (64) @(posedge pclk);
      n = bp_n;
      repeat (320) @(posedge pclk);
      n = bp_n - n;
      chk(32'(n >= (16'h13 << s) && n <= (16'h15 << s)), 32'h1);
    end
    $display("t_bp done");
  endtask : t_bp
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  initial begin
    #200us;
    error_cnt++;
    give_verdict;
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_rx64;
    t_56k;
    t_tx;
    t_e1;
    t_bp;
    give_verdict;
  end
endmodule : testbench
`default_nettype wire
